//--- verilog/tic_top.v
// tile input conditioning: pin qualification, source routing and eight
// filtered tile inputs, configured over APB; one clock pclk
`include "tic_regs.vh"
`default_nettype none

module tic_top #(
   parameter NPIN = 4,
   parameter NPER = 4,
   parameter NGP = 8,
   parameter WIN_W = `TIC_WIN_W
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [NPIN-1:0] ext_pins,
   input wire [NPER-1:0] periph_in,
   output reg [7:0] tile_in,
   output reg [1:0] bypass_out,
   output reg [7:0] cpu_general_purpose_bits
);
   localparam NSRC = NPIN + NPER + NGP;

   // ==================================================================
   // register indices, produced once from paddr by reg_index
   localparam [2:0] RI_QUAL_CFG = 3'h0;
   localparam [2:0] RI_QUAL_WIN = 3'h1;
   localparam [2:0] RI_SRC_SEL = 3'h2;
   localparam [2:0] RI_IN_CFG = 3'h3;
   localparam [2:0] RI_GP_BITS = 3'h4;
   localparam [2:0] RI_STATUS = 3'h5;
   localparam [2:0] RI_NONE = 3'h7;

   // ==================================================================
   // reset images, cut into the fields that each register holds
   localparam [31:0] QUAL_CFG_RST = `TIC_QUAL_CFG_RST;
   localparam [23:0] IN_CFG_RST = `TIC_IN_CFG_RST;

   // ==================================================================
   // register state
   reg [2*NPIN-1:0] qual_mode_r;
   reg [NPIN-1:0] qual_inv_r;
   reg [WIN_W-1:0] qual_win_r;
   reg [31:0] src_sel_r;
   reg [7:0] in_sync_r;
   reg [15:0] in_filt_r;
   reg [7:0] gp_bits_r;
   reg [NPIN-1:0] stat_pin1_r;
   reg [NPIN-1:0] stat_pin2_r;

   // bus side
   reg pready_r;
   reg [31:0] prdata_r;
   reg pslverr_r;
   reg [31:0] prdata_nxt;
   reg addr_ok;

   wire [NPIN-1:0] pin_q;
   wire [7:0] filt_w;
   wire [NSRC-1:0] src_vec;
   reg [7:0] routed;
   integer k;

   wire acc = psel & penable;
   wire done = acc & pready_r;
   wire wr = done & pwrite & addr_ok;

   // source codes: pins from 0, then peripherals, then cpu bits; a
   // code past the last source reads 0 in sel_bit
   assign src_vec = {gp_bits_r[NGP-1:0], periph_in, pin_q};

   // ==================================================================
   // source select and address decode helpers
   function sel_bit;
      input [NSRC-1:0] v;
      input [`TIC_SEL_W-1:0] s;
      begin
         // codes past the last source read 0 rather than unknown
         if (s < NSRC) begin
            sel_bit = v[s];
         end else begin
            sel_bit = 1'b0;
         end
      end
   endfunction

   function [2:0] reg_index;
      input [11:0] a;
      begin
         case (a)
            `TIC_QUAL_CFG_OFF: reg_index = RI_QUAL_CFG;
            `TIC_QUAL_WIN_OFF: reg_index = RI_QUAL_WIN;
            `TIC_SRC_SEL_OFF: reg_index = RI_SRC_SEL;
            `TIC_IN_CFG_OFF: reg_index = RI_IN_CFG;
            `TIC_GP_BITS_OFF: reg_index = RI_GP_BITS;
            `TIC_STATUS_OFF: reg_index = RI_STATUS;
            default: reg_index = RI_NONE;
         endcase
      end
   endfunction

   // unmapped offsets decode to RI_NONE and answer with pslverr
   wire [2:0] ridx = reg_index(paddr);
   wire gp_wr = wr & (ridx == RI_GP_BITS);

   // ==================================================================
   // pin qualification stage
   genvar g;
   generate
      for (g = 0; g < NPIN; g = g + 1) begin : g_pin
         tic_pin_qual #(
            .WIN_W(WIN_W)
         ) u_pin (
            .pclk(pclk),
            .presetn(presetn),
            .pin(ext_pins[g]),
            .mode(qual_mode_r[2*g+1:2*g]),
            .invert(qual_inv_r[g]),
            .win_len(qual_win_r),
            .qual_out(pin_q[g])
         );
      end
   endgenerate

   // ==================================================================
   // local routing: each input picks any source independently
   always @* begin
      routed = 8'h00;
      for (k = 0; k < 8; k = k + 1) begin
         routed[k] = sel_bit(src_vec, src_sel_r[4*k +: 4]);
      end
   end

   // ==================================================================
   // per-input synchronisation and filter
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_in
         tic_edge_filt u_filt (
            .pclk(pclk),
            .presetn(presetn),
            .raw_in(routed[g]),
            .sync_en(in_sync_r[g]),
            .filt(in_filt_r[2*g+1:2*g]),
            .filt_out(filt_w[g])
         );
      end
   endgenerate

   // ==================================================================
   // tile-side outputs
   // registering keeps pulses exactly one clock wide, one cycle later
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tile_in <= 8'h00;
      end else begin
         tile_in <= filt_w;
      end
   end

   // ==================================================================
   // qualified pins resynchronised for status; in async pin mode they
   // would otherwise reach a bus register straight from the pin
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_pin1_r <= {NPIN{1'b0}};
         stat_pin2_r <= {NPIN{1'b0}};
      end else begin
         stat_pin1_r <= pin_q;
         stat_pin2_r <= stat_pin1_r;
      end
   end

   // unsynchronised path: combinational so no clock alignment is added;
   // only inputs 4 and 5 may carry it, and only when not synchronised
   always @* begin
      bypass_out[0] = routed[4] & ~in_sync_r[4];
      bypass_out[1] = routed[5] & ~in_sync_r[5];
   end

   // ==================================================================
   // apb decode
   always @* begin
      addr_ok = 1'b1;
      prdata_nxt = 32'h0000_0000;
      case (ridx)
         RI_QUAL_CFG: begin
            prdata_nxt[2*NPIN-1:0] = qual_mode_r;
            prdata_nxt[`TIC_QUAL_INV_LSB +: NPIN] = qual_inv_r;
         end
         RI_QUAL_WIN: prdata_nxt[WIN_W-1:0] = qual_win_r;
         RI_SRC_SEL: prdata_nxt = src_sel_r;
         RI_IN_CFG: begin
            prdata_nxt[`TIC_IN_SYNC_LSB +: 8] = in_sync_r;
            prdata_nxt[`TIC_IN_FILT_LSB +: 16] = in_filt_r;
         end
         RI_GP_BITS: prdata_nxt[7:0] = gp_bits_r;
         RI_STATUS: begin
            prdata_nxt[7:0] = tile_in;
            prdata_nxt[`TIC_STAT_PIN_LSB +: NPIN] = stat_pin2_r;
         end
         default: addr_ok = 1'b0;
      endcase
   end

   // ==================================================================
   // apb handshake: one wait state, answer on second access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= acc & ~pready_r;
         if (acc & ~pready_r) begin
            prdata_r <= pwrite ? 32'h0000_0000 : prdata_nxt;
            pslverr_r <= ~addr_ok;
         end else begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
         end
      end
   end

   always @* begin
      pready = pready_r;
      prdata = prdata_r;
      pslverr = pslverr_r;
   end

   // ==================================================================
   // pin stage configuration
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qual_mode_r <= QUAL_CFG_RST[2*NPIN-1:0];
         qual_inv_r <= QUAL_CFG_RST[`TIC_QUAL_INV_LSB +: NPIN];
         qual_win_r <= `TIC_QUAL_WIN_RST;
      end else if (wr) begin
         case (ridx)
            RI_QUAL_CFG: begin
               qual_mode_r <= pwdata[2*NPIN-1:0];
               qual_inv_r <= pwdata[`TIC_QUAL_INV_LSB +: NPIN];
            end
            RI_QUAL_WIN: qual_win_r <= pwdata[WIN_W-1:0];
            default: qual_win_r <= qual_win_r;
         endcase
      end
   end

   // ==================================================================
   // routing, tile input and cpu bit configuration
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_sel_r <= `TIC_SRC_SEL_RST;
         in_sync_r <= IN_CFG_RST[`TIC_IN_SYNC_LSB +: 8];
         in_filt_r <= IN_CFG_RST[`TIC_IN_FILT_LSB +: 16];
         gp_bits_r <= `TIC_GP_BITS_RST;
      end else if (wr) begin
         case (ridx)
            RI_SRC_SEL: src_sel_r <= pwdata;
            RI_IN_CFG: begin
               in_sync_r <= pwdata[`TIC_IN_SYNC_LSB +: 8];
               in_filt_r <= pwdata[`TIC_IN_FILT_LSB +: 16];
            end
            RI_GP_BITS: gp_bits_r <= pwdata[7:0];
            default: gp_bits_r <= gp_bits_r;
         endcase
      end
   end

   // ==================================================================
   // cpu bits also visible outside
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_general_purpose_bits <= `TIC_GP_BITS_RST;
      end else if (gp_wr) begin
         cpu_general_purpose_bits <= pwdata[7:0];
      end
   end
endmodule // tic_top
`default_nettype wire

//--- verilog/tic_regs.vh
// register map, field positions, reset values and encodings of the
// tile input conditioning block; definitions only
`ifndef TIC_REGS_VH
`define TIC_REGS_VH

// ==================================================================
// register byte offsets
`define TIC_QUAL_CFG_OFF 12'h000
`define TIC_QUAL_WIN_OFF 12'h004
`define TIC_SRC_SEL_OFF 12'h008
`define TIC_IN_CFG_OFF 12'h00c
`define TIC_GP_BITS_OFF 12'h010
`define TIC_STATUS_OFF 12'h014

// ==================================================================
// field positions
`define TIC_QUAL_INV_LSB 8
`define TIC_IN_SYNC_LSB 0
`define TIC_IN_FILT_LSB 8
`define TIC_STAT_PIN_LSB 8

// ==================================================================
// reset values
`define TIC_QUAL_CFG_RST 32'h0000_0000
`define TIC_QUAL_WIN_RST 8'h03
`define TIC_SRC_SEL_RST 32'h7654_3210
`define TIC_IN_CFG_RST 24'h00_00ff
`define TIC_GP_BITS_RST 8'h00

// ==================================================================
// pin qualification modes, two bits per pin
`define TIC_QM_ASYNC 2'h0
`define TIC_QM_SYNC 2'h1
`define TIC_QM_WINDOW 2'h2

// ==================================================================
// tile input filter modes, two bits per input
`define TIC_FM_NONE 2'h0
`define TIC_FM_RISE 2'h1
`define TIC_FM_FALL 2'h2
`define TIC_FM_ANY 2'h3

// ==================================================================
// widths and timing
`define TIC_WIN_W 8
`define TIC_SEL_W 4
`define TIC_SYNC_STAGES 2

`endif

//--- verilog/tic_pin_qual.v
// pin qualification for one external pin: async, sync or sampling window,
// with optional inversion; assumes pclk domain, pin async to it
`include "tic_regs.vh"
`default_nettype none

module tic_pin_qual #(
   parameter WIN_W = `TIC_WIN_W
) (
   input wire pclk,
   input wire presetn,
   input wire pin,
   input wire [1:0] mode,
   input wire invert,
   input wire [WIN_W-1:0] win_len,
   output reg qual_out
);
   reg sync1_r;
   reg sync2_r;
   reg held_r;
   reg [WIN_W-1:0] stab_cnt_r;
   wire [WIN_W:0] stab_sum = stab_cnt_r + 1'b1;
   wire pin_i = pin ^ invert;

   // ==================================================================
   // synchroniser and stability counter
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         held_r <= 1'b0;
         stab_cnt_r <= {WIN_W{1'b0}};
      end else begin
         sync1_r <= pin_i;
         sync2_r <= sync1_r;
         // new level accepted only after win_len stable cycles
         if (sync2_r == held_r) begin
            stab_cnt_r <= {WIN_W{1'b0}};
         end else if (stab_sum >= {1'b0, win_len}) begin
            held_r <= sync2_r;
            stab_cnt_r <= {WIN_W{1'b0}};
         end else begin
            stab_cnt_r <= stab_sum[WIN_W-1:0];
         end
      end
   end

   // ==================================================================
   // mode select; async path stays combinational on purpose
   always @* begin
      case (mode)
         `TIC_QM_ASYNC: qual_out = pin_i;
         `TIC_QM_SYNC: qual_out = sync2_r;
         `TIC_QM_WINDOW: qual_out = held_r;
         default: qual_out = pin_i;
      endcase
   end
endmodule // tic_pin_qual
`default_nettype wire

//--- verilog/tic_edge_filt.v
// one tile input: optional synchronisation then level or edge filter;
// assumes pclk domain, input may be async to it
`include "tic_regs.vh"
`default_nettype none

module tic_edge_filt (
   input wire pclk,
   input wire presetn,
   input wire raw_in,
   input wire sync_en,
   input wire [1:0] filt,
   output reg filt_out
);
   reg sync1_r;
   reg sync2_r;
   reg prev_r;
   wire cur;

   // ==================================================================
   // synchroniser and previous sample
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         sync1_r <= raw_in;
         sync2_r <= sync1_r;
         prev_r <= cur;
      end
   end

   // unsynchronised choice is for pass-through only; edges on it may glitch
   assign cur = sync_en ? sync2_r : raw_in;

   // ==================================================================
   // filter select
   always @* begin
      case (filt)
         `TIC_FM_NONE: filt_out = cur;
         `TIC_FM_RISE: filt_out = cur & ~prev_r;
         `TIC_FM_FALL: filt_out = ~cur & prev_r;
         `TIC_FM_ANY: filt_out = cur ^ prev_r;
         default: filt_out = cur;
      endcase
   end
endmodule // tic_edge_filt
`default_nettype wire

//--- verif/tic_top_props.sv
// checker for tic_top: bus handshake, cpu bit copy, bypass gating, pulses
// assumes a bind onto tic_top and the register header on the include path
`include "tic_regs.vh"
`default_nettype none
module tic_top_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [7:0] tile_in,
   input wire logic [1:0] bypass_out,
   input wire logic [7:0] cpu_general_purpose_bits
);
   timeunit 1ns;
   timeprecision 1ps;
   // ======
   // shadow of written settings, seen only from the bus
   logic [23:0] cfg_r;
   logic [7:0] gp_r;
   wire logic wr_hit = psel && penable && pready && pwrite;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r <= 24'h0000ff;
         gp_r <= 8'h00;
      end else if (wr_hit && paddr == `TIC_IN_CFG_OFF) begin
         cfg_r <= pwdata[23:0];
      end else if (wr_hit && paddr == `TIC_GP_BITS_OFF) begin
         gp_r <= pwdata[7:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ======
   // properties
   AST_RDY_ONE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_RDY_LAT: assert property (psel && penable && !$past(penable) |=> pready)
      else $error("no answer after one wait state");
   AST_RDY_CAUSE: assert property (pready |-> psel && $past(penable))
      else $error("pready without access");
   AST_RD_IDLE: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer cycle");
   AST_ERR_MAP: assert property (pready |-> pslverr == !(paddr inside {
      `TIC_QUAL_CFG_OFF, `TIC_QUAL_WIN_OFF, `TIC_SRC_SEL_OFF,
      `TIC_IN_CFG_OFF, `TIC_GP_BITS_OFF, `TIC_STATUS_OFF}))
      else $error("error response wrong for address");
   AST_GP_COPY: assert property (
      wr_hit && paddr == `TIC_GP_BITS_OFF |-> ##[1:2] cpu_general_purpose_bits == gp_r)
      else $error("cpu bits not updated");
   AST_BYP_GATE: assert property ((bypass_out & cfg_r[5:4]) == 2'h0)
      else $error("bypass open while input synchronised");
   AST_RST_QUIET: assert property ($rose(presetn) |-> (tile_in == 8'h00) [*2])
      else $error("tile input active right after reset");
   for (genvar k = 0; k < 8; k++) begin : g_edge
      AST_EDGE_PULSE: assert property (
         tile_in[k] && $stable(cfg_r[8+2*k +: 2]) && (cfg_r[8+2*k +: 2] == `TIC_FM_RISE
         || cfg_r[8+2*k +: 2] == `TIC_FM_FALL) |=> !tile_in[k])
         else $error("edge pulse longer than one cycle");
   end
endmodule // tic_top_props
`default_nettype wire

//--- verif/tic_far_model.sv
// far side: external pins and peripheral lines feeding the block
// assumes the bench calls its tasks; changes land just after a clock edge
`default_nettype none
module tic_far_model (
   input wire logic pclk,
   output logic [3:0] ext_pins,
   output logic [3:0] periph_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      ext_pins = 4'h0;
      periph_in = 4'h0;
   end
   task put(input logic [3:0] p, input logic [3:0] q);
      @(posedge pclk);
      ext_pins <= p;
      periph_in <= q;
   endtask
   // serial clock on pin 0, idles low between frames
   task sclk(input int n, input int h);
      for (int i = 0; i < n; i++) begin
         repeat (h) @(posedge pclk);
         ext_pins[0] <= 1'b1;
         repeat (h) @(posedge pclk);
         ext_pins[0] <= 1'b0;
      end
   endtask
endmodule // tic_far_model
`default_nettype wire

//--- verif/test_tile_input_conditioning.sv
// testbench for tic_top: bus tasks and scenario sequence
// assumes tic_far_model for the pins and the checker bound at the foot
`include "tic_regs.vh"
`default_nettype none
module test_tile_input_conditioning;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] ext_pins, periph_in;
   logic [7:0] tile_in, gp;
   logic [1:0] bypass_out;
   int num_errors, n_tests;
   int cnt[8], base[8];
   tic_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_pins(ext_pins), .periph_in(periph_in), .tile_in(tile_in),
      .bypass_out(bypass_out), .cpu_general_purpose_bits(gp));
   tic_far_model far_u (.pclk(pclk), .ext_pins(ext_pins), .periph_in(periph_in));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // cycles high per tile input, differenced to count pulses
   always @(posedge pclk) for (int k = 0; k < 8; k++) cnt[k] <= cnt[k] + tile_in[k];
   // ======
   // tasks
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wait_n(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task mark;
      base = cnt;
   endtask
   task pulses(input int k, input int exp);
      chk(32'(cnt[k] - base[k]), 32'(exp));
   endtask
   task close_out;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ======
   // scenarios
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      presetn = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      xfer(1'b0, `TIC_QUAL_WIN_OFF, 32'h0);
      chk(rd, 32'h0000_0003);
      xfer(1'b0, `TIC_SRC_SEL_OFF, 32'h0);
      chk(rd, 32'h7654_3210);
      xfer(1'b0, 12'h020, 32'h0);
      chk(rd, 32'h0);
      chk(32'(err), 32'h1);
      $display("test reset_map done");
      // pin 0 fans out to inputs 0..3 with none, rise, fall, any
      xfer(1'b1, `TIC_SRC_SEL_OFF, 32'h9841_0000);
      xfer(1'b1, `TIC_IN_CFG_OFF, 32'h0000_e4ff);
      wait_n(6);
      mark;
      far_u.put(4'h1, 4'h0);
      wait_n(2);
      chk(32'(tile_in[0]), 32'h0);
      wait_n(8);
      chk(32'(tile_in[0]), 32'h1);
      pulses(1, 1);
      pulses(2, 0);
      pulses(3, 1);
      mark;
      far_u.put(4'h0, 4'h0);
      wait_n(10);
      chk(32'(tile_in[0]), 32'h0);
      pulses(1, 0);
      pulses(2, 1);
      pulses(3, 1);
      mark;
      far_u.sclk(5, 2);
      wait_n(8);
      pulses(1, 5);
      pulses(3, 10);
      $display("test edges done");
      xfer(1'b1, `TIC_GP_BITS_OFF, 32'h0000_0002);
      far_u.put(4'h2, 4'h1);
      wait_n(6);
      chk(32'(tile_in[7:5]), 32'h5);
      chk(32'(gp), 32'h02);
      xfer(1'b1, `TIC_IN_CFG_OFF, 32'h0000_e4ef);
      wait_n(1);
      chk(32'(bypass_out[0]), 32'h1);
      chk(32'(bypass_out[1]), 32'h0);
      far_u.put(4'h0, 4'h1);
      #1;
      chk(32'(bypass_out[0]), 32'h0);
      $display("test routing done");
      xfer(1'b1, `TIC_QUAL_CFG_OFF, 32'h0000_0100);
      wait_n(6);
      chk(32'(tile_in[0]), 32'h1);
      xfer(1'b1, `TIC_QUAL_WIN_OFF, 32'h0000_0005);
      xfer(1'b1, `TIC_QUAL_CFG_OFF, 32'h0000_0002);
      wait_n(12);
      mark;
      far_u.put(4'h1, 4'h1);
      far_u.put(4'h0, 4'h1);
      wait_n(12);
      pulses(0, 0);
      far_u.put(4'h1, 4'h1);
      wait_n(14);
      chk(32'(tile_in[0]), 32'h1);
      $display("test qualify done");
      close_out;
   end
   // whole sequence needs well under 1000 cycles
   initial begin
      #40000;
      num_errors++;
      close_out;
   end
endmodule // test_tile_input_conditioning
bind tic_top tic_top_props props_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .tile_in(tile_in), .bypass_out(bypass_out),
   .cpu_general_purpose_bits(cpu_general_purpose_bits));
`default_nettype wire
